// ==== phy_vendor_status_config_regs.sv ====
// register bank for three vendor management registers of a 10/100 transceiver
// assumes: the management frame decoder sits on sys_clk and hands over whole
// 16-bit accesses already matched to this phy; status inputs come from
// other logic on sys_clk except the strap and polarity detector, which are pins
// a write landing before or on the strap load cycle is dropped, so the decoder
// keeps the first three cycles after reset release quiet
// reads and writes are not expected in the same cycle
`timescale 1ns/1ps

module phy_vendor_status_config_regs
   import phy_vendor_regs_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // management access, one-cycle strobes, same clock domain
   input  wire logic        mgmt_wr,
   input  wire logic        mgmt_rd,
   input  wire logic [4:0]  mgmt_reg,
   input  wire logic [15:0] mgmt_wdata,
   output logic [15:0]      mgmt_rdata,
   output logic             mgmt_rvalid,
   // straps, pins sampled at reset release
   input  wire logic [4:0]  addr_strap,
   input  wire logic        serial_strap,
   // negotiation and link state from the link logic
   input  wire logic        neg_enabled,
   input  wire logic        neg_done,
   input  wire logic [3:0]  neg_mode,
   input  wire logic [3:0]  neg_state,
   input  wire logic        speed_fast,
   input  wire logic        full_duplex,
   input  wire logic        tp_loopback,
   input  wire logic        raw_link_ok,
   input  wire logic        polarity_rev_pin,
   // controls toward the data path
   output logic [4:0]       phy_addr_field,
   output logic             send_link_pulses,
   output logic             link_good,
   output logic             heartbeat_active,
   output logic             squelch_normal,
   output logic             jabber_active,
   output logic             general_serial_interface,
   output logic [8:0]       pd_subfunction,
   // shared power-down value, held elsewhere
   input  wire logic        shared_pd_level,
   input  wire logic [8:0]  pd_select
);

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  strap_pend;
      logic [1:0]  strap_sync;
      logic [4:0]  addr_sync0;
      logic [4:0]  addr_sync1;
      logic [1:0]  pol_sync;
      logic [3:0]  res_mode;
      logic [4:0]  phy_addr;
      logic [3:0]  monitor;
      logic        link_pulse_on;
      logic        heartbeat_on;
      logic        squelch_on;
      logic        jabber_on;
      logic        serial_if_select;
      logic        polarity_reversed_flag;
      logic [8:0]  pd_test;
      logic [15:0] rdata;
      logic        rvalid;
   } regs_s;

   regs_s state_q;
   regs_s state_d;

   logic [15:0] mode_word;
   logic [15:0] tenbase_word;
   logic [15:0] pd_word;
   logic        slow_speed;

   // 10BASE-T option scope; loopback stands apart because the jabber bit
   // covers it whatever the duplex setting is
   typedef enum logic [1:0] {
      op_fast,
      op_slow_half,
      op_slow_full,
      op_slow_loop
   } op_mode_e;

   logic [4:0]  addr_strap_sync;
   logic        serial_strap_sync;
   logic        polarity_sync;
   logic        strap_load;
   logic        wr_allowed;
   logic [15:0] read_word;
   op_mode_e    op_mode;

   // ---------------------------------------------------------------------
   // read words; reserved bits are zero
   // ---------------------------------------------------------------------
   always_comb begin
      mode_word = 16'h0000;
      mode_word[res_fast_full_pos:res_slow_half_pos] = state_q.res_mode;
      mode_word[phy_addr_lsb +: 5]                   = state_q.phy_addr;
      mode_word[monitor_lsb +: 4]                    = state_q.monitor;
      tenbase_word = 16'h0000;
      tenbase_word[link_pulse_on_pos]    = state_q.link_pulse_on;
      tenbase_word[heartbeat_on_pos]     = state_q.heartbeat_on;
      tenbase_word[squelch_normal_pos]   = state_q.squelch_on;
      tenbase_word[jabber_on_pos]        = state_q.jabber_on;
      tenbase_word[serial_if_select_pos] = state_q.serial_if_select;
      tenbase_word[polarity_flag_pos]    = state_q.polarity_reversed_flag;
      pd_word = {7'h00, state_q.pd_test};
   end

   // ---------------------------------------------------------------------
   // synchronised pins and access qualifiers
   // ---------------------------------------------------------------------
   assign addr_strap_sync   = state_q.addr_sync1;
   assign serial_strap_sync = state_q.strap_sync[1];
   assign polarity_sync     = state_q.pol_sync[1];

   // the synchronisers restart from zero in reset, so the load waits for stage two
   assign strap_load = (state_q.strap_pend == 2'h1);
   assign wr_allowed = mgmt_wr && (state_q.strap_pend == 2'h0);

   // ---------------------------------------------------------------------
   // read multiplexer; unmapped numbers read zero
   // ---------------------------------------------------------------------
   always_comb begin
      case (mgmt_reg)
         link_mode_status_addr:        read_word = mode_word;
         tenbase_config_status_addr:   read_word = tenbase_word;
         power_down_test_control_addr: read_word = pd_word;
         default:                      read_word = 16'h0000;
      endcase
   end

   // ---------------------------------------------------------------------
   // operating mode seen by the 10BASE-T options
   // ---------------------------------------------------------------------
   always_comb begin
      if (speed_fast) begin
         op_mode = op_fast;
      end else if (tp_loopback) begin
         op_mode = op_slow_loop;
      end else if (full_duplex) begin
         op_mode = op_slow_full;
      end else begin
         op_mode = op_slow_half;
      end
   end

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   always_comb begin
      state_d = state_q;

      // pins pass two flops; only the second stage is read
      state_d.strap_sync = {state_q.strap_sync[0], serial_strap};
      state_d.addr_sync0 = addr_strap;
      state_d.addr_sync1 = state_q.addr_sync0;
      state_d.pol_sync   = {state_q.pol_sync[0], polarity_rev_pin};

      // straps land a few cycles after release, once the synchronisers filled;
      // a management write in that window is dropped, so the
      // frame decoder is expected to stay quiet for the first three cycles
      if (state_q.strap_pend != 2'h0) begin
         state_d.strap_pend = state_q.strap_pend - 2'h1;
      end
      if (strap_load) begin
         state_d.phy_addr         = addr_strap_sync;
         state_d.serial_if_select = serial_strap_sync;
      end

      // status fields are owned by hardware; writes never reach them
      if (neg_done) begin
         state_d.res_mode = neg_mode;
      end
      state_d.monitor                = neg_state;
      state_d.polarity_reversed_flag = polarity_sync;

      if (wr_allowed) begin
         case (mgmt_reg)
            link_mode_status_addr: begin
               state_d.phy_addr = mgmt_wdata[phy_addr_lsb +: 5];
            end
            tenbase_config_status_addr: begin
               state_d.link_pulse_on    = mgmt_wdata[link_pulse_on_pos];
               state_d.heartbeat_on     = mgmt_wdata[heartbeat_on_pos];
               state_d.squelch_on       = mgmt_wdata[squelch_normal_pos];
               state_d.jabber_on        = mgmt_wdata[jabber_on_pos];
               state_d.serial_if_select = mgmt_wdata[serial_if_select_pos];
            end
            power_down_test_control_addr: begin
               state_d.pd_test = mgmt_wdata[pd_test_width-1:0];
            end
            default: begin
            end
         endcase
      end

      // read data registered one cycle after the strobe
      state_d.rvalid = mgmt_rd;
      if (mgmt_rd) begin
         state_d.rdata = read_word;
      end
   end

   // ---------------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q                        <= '0;
         // zero covers the address, serial select, synchronisers and read port
         state_q.strap_pend             <= strap_wait_reset;
         state_q.res_mode               <= res_mode_reset;
         state_q.monitor                <= monitor_reset;
         state_q.link_pulse_on          <= link_pulse_on_reset;
         state_q.heartbeat_on           <= heartbeat_on_reset;
         state_q.squelch_on             <= squelch_normal_reset;
         state_q.jabber_on              <= jabber_on_reset;
         state_q.polarity_reversed_flag <= polarity_flag_reset;
         state_q.pd_test                <= pd_test_reset;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------------
   // controls toward the data path
   // ---------------------------------------------------------------------
   assign slow_speed     = !speed_fast;
   assign mgmt_rdata     = state_q.rdata;
   assign mgmt_rvalid    = state_q.rvalid;
   assign phy_addr_field = state_q.phy_addr;

   // heartbeat has no meaning in full duplex, so the bit is masked there
   assign heartbeat_active = state_q.heartbeat_on && !full_duplex;
   assign squelch_normal   = state_q.squelch_on;

   // the pulse bit and the serial select only matter at 10M; at 100M the
   // receiver's link status passes straight through and serial is forced off
   always_comb begin
      send_link_pulses         = 1'b0;
      link_good                = raw_link_ok;
      general_serial_interface = 1'b0;
      if (slow_speed) begin
         send_link_pulses         = state_q.link_pulse_on;
         link_good                = raw_link_ok || !state_q.link_pulse_on;
         general_serial_interface = state_q.serial_if_select;
      end
   end

   // jabber protection in 10M half duplex cannot be switched off; the bit
   // only has a say in full duplex and in transceiver loopback
   always_comb begin
      case (op_mode)
         op_fast: begin
            jabber_active = 1'b0;
         end
         op_slow_half: begin
            jabber_active = 1'b1;
         end
         op_slow_full,
         op_slow_loop: begin
            jabber_active = state_q.jabber_on;
         end
         default: begin
            jabber_active = 1'b0;
         end
      endcase
   end

   // per-field mux: selected fields follow the shared level, 1 = power down
   always_comb begin
      for (int i = 0; i < pd_test_width; i++) begin
         pd_subfunction[i] = pd_select[i] ? shared_pd_level : state_q.pd_test[i];
      end
   end

endmodule : phy_vendor_status_config_regs

// ==== phy_vendor_regs_pkg.sv ====
// package: offsets, field positions, reset values and codes of the vendor management registers
// assumes: used by the register bank and its testbench only
package phy_vendor_regs_pkg;

   // --------------------------------------------------------------------
   // register offsets (management register numbers)
   // --------------------------------------------------------------------
   localparam logic [4:0] link_mode_status_addr        = 5'h11;
   localparam logic [4:0] tenbase_config_status_addr   = 5'h12;
   localparam logic [4:0] power_down_test_control_addr = 5'h13;

   // --------------------------------------------------------------------
   // link_mode_status fields
   // --------------------------------------------------------------------
   localparam int res_fast_full_pos = 15;
   localparam int res_fast_half_pos = 14;
   localparam int res_slow_full_pos = 13;
   localparam int res_slow_half_pos = 12;
   localparam int phy_addr_lsb      = 4;
   localparam int monitor_lsb       = 0;
   localparam logic [3:0] res_mode_reset = 4'hF;
   localparam logic [3:0] monitor_reset  = 4'h0;

   // one-hot resolved modes, bit 3 = fast full down to bit 0 = slow half
   localparam logic [3:0] mode_fast_full = 4'h8;
   localparam logic [3:0] mode_fast_half = 4'h4;
   localparam logic [3:0] mode_slow_full = 4'h2;
   localparam logic [3:0] mode_slow_half = 4'h1;

   // negotiation monitor codes
   localparam logic [3:0] mon_idle         = 4'h0;
   localparam logic [3:0] mon_ability      = 4'h1;
   localparam logic [3:0] mon_ack_match    = 4'h2;
   localparam logic [3:0] mon_ack_fail     = 4'h3;
   localparam logic [3:0] mon_consist      = 4'h4;
   localparam logic [3:0] mon_consist_fail = 4'h5;
   localparam logic [3:0] mon_pd_ready     = 4'h6;
   localparam logic [3:0] mon_pd_fail      = 4'h7;
   localparam logic [3:0] mon_complete     = 4'h8;

   // --------------------------------------------------------------------
   // tenbase_config_status fields
   // --------------------------------------------------------------------
   localparam int link_pulse_on_pos    = 14;
   localparam int heartbeat_on_pos     = 13;
   localparam int squelch_normal_pos   = 12;
   localparam int jabber_on_pos        = 11;
   localparam int serial_if_select_pos = 10;
   localparam int polarity_flag_pos    = 0;
   localparam logic link_pulse_on_reset  = 1'b1;
   localparam logic heartbeat_on_reset   = 1'b1;
   localparam logic squelch_normal_reset = 1'b1;
   localparam logic jabber_on_reset      = 1'b1;
   localparam logic polarity_flag_reset  = 1'b0;

   // --------------------------------------------------------------------
   // power_down_test_control fields
   // --------------------------------------------------------------------
   localparam int          pd_test_width = 9;
   localparam logic [8:0]  pd_test_reset = 9'h000;

   // countdown from reset release to strap capture; covers both synchroniser stages
   localparam logic [1:0]  strap_wait_reset = 2'h3;

endpackage : phy_vendor_regs_pkg

// ==== mgmt_model.sv ====
// station management model: whole 16-bit reads and writes over the strobe port
// assumes: requests taken at rising sys_clk, read answer one cycle later
`timescale 1ns/1ps
module mgmt_model (
   // clock
   input  wire logic        sys_clk,
   // access port
   output logic             mgmt_wr,
   output logic             mgmt_rd,
   output logic [4:0]       mgmt_reg,
   output logic [15:0]      mgmt_wdata,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        mgmt_rvalid
);
   initial begin
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_reg = 5'h00;
      mgmt_wdata = 16'h0000;
   end
   // requests change at the falling edge, held across the taking edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      mgmt_reg = a;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      @(negedge sys_clk);
      mgmt_wr = 1'b0;
      // released data must not keep the last word alive
      mgmt_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      mgmt_reg = a;
      mgmt_rd = 1'b1;
      @(negedge sys_clk);
      mgmt_rd = 1'b0;
      d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hXXXX;
   endtask : rd
endmodule : mgmt_model

// ==== phy_vendor_status_config_regs_properties.sv ====
// checker for the vendor register bank: read timing and field relations
// assumes: one clock domain, bound to every bank instance
`timescale 1ns/1ps
module phy_vendor_regs_checker (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        mgmt_rd,
   input wire logic [4:0]  mgmt_reg,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        neg_done,
   input wire logic [3:0]  neg_mode,
   input wire logic [3:0]  neg_state,
   input wire logic        speed_fast,
   input wire logic        full_duplex,
   input wire logic        shared_pd_level,
   input wire logic [8:0]  pd_select,
   input wire logic [4:0]  phy_addr_field,
   input wire logic        send_link_pulses,
   input wire logic        link_good,
   input wire logic        heartbeat_active,
   input wire logic        general_serial_interface,
   input wire logic [8:0]  pd_subfunction
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_reserved_mode_zero: assert property (mgmt_rd && mgmt_reg == 5'h11 |=>
      mgmt_rdata[11:9] == 3'b000) else $error("mode word reserved bits set");
   a_addr_read_match: assert property (mgmt_rd && mgmt_reg == 5'h11 |=>
      mgmt_rdata[8:4] == $past(phy_addr_field)) else $error("address field read differs");
   a_monitor_copy: assert property (mgmt_rd && mgmt_reg == 5'h11 &&
      neg_state == $past(neg_state) |=> mgmt_rdata[3:0] == $past(neg_state))
      else $error("monitor code read differs");
   a_resmode_load: assert property (neg_done ##1 !neg_done ##1
      (mgmt_rd && mgmt_reg == 5'h11 && !neg_done) |=> mgmt_rdata[15:12] == $past(neg_mode, 3))
      else $error("resolved mode not loaded");
   a_pd_word_upper: assert property (mgmt_rd && mgmt_reg == 5'h13 |=>
      mgmt_rdata[15:9] == 7'h00) else $error("power-down word upper bits set");
   a_pd_select_mux: assert property ((pd_subfunction & pd_select) ==
      ({9{shared_pd_level}} & pd_select)) else $error("selected power-down wrong");
   a_pulses_slow_only: assert property (speed_fast |-> !send_link_pulses)
      else $error("link pulses at fast speed");
   a_link_good_forced: assert property (!speed_fast && !send_link_pulses |-> link_good)
      else $error("good link not forced");
   a_heartbeat_fdx: assert property (full_duplex |-> !heartbeat_active)
      else $error("heartbeat in full duplex");
   a_serial_slow_only: assert property (speed_fast |-> !general_serial_interface)
      else $error("serial interface at fast speed");
endmodule : phy_vendor_regs_checker
bind phy_vendor_status_config_regs phy_vendor_regs_checker phy_vendor_regs_checker_inst (.*);

// ==== tb_phy_vendor_status_config_regs.sv ====
// testbench for the vendor register bank, driven through the management model
// assumes: straps steady from time zero, inputs change at the falling edge
`timescale 1ns/1ps
module tb_phy_vendor_status_config_regs;
   import phy_vendor_regs_pkg::*;
   logic sys_clk, rst_b, mgmt_wr, mgmt_rd, mgmt_rvalid, serial_strap, neg_enabled, neg_done;
   logic speed_fast, full_duplex, tp_loopback, raw_link_ok, polarity_rev_pin, link_good;
   logic send_link_pulses, heartbeat_active, squelch_normal, jabber_active, shared_pd_level;
   logic general_serial_interface;
   logic [4:0]  mgmt_reg, addr_strap, phy_addr_field;
   logic [15:0] mgmt_wdata, mgmt_rdata;
   logic [3:0]  neg_mode, neg_state;
   logic [8:0]  pd_subfunction, pd_select;
   logic [3:0]  modes [4] = '{mode_fast_full, mode_fast_half, mode_slow_full, mode_slow_half};
   int          error_cnt = 0;
   int          check_count = 0;
   phy_vendor_status_config_regs phy_vendor_status_config_regs_inst (.*);
   mgmt_model mgmt_model_inst (.*);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rc(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      mgmt_model_inst.rd(a, d);
      chk(d, exp);
   endtask : rc
   // packed view of the data-path controls: pulses, link, heartbeat, squelch, jabber, serial
   function automatic logic [15:0] ctl();
      return {10'h000, send_link_pulses, link_good, heartbeat_active, squelch_normal,
              jabber_active, general_serial_interface};
   endfunction : ctl
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      {rst_b, neg_done, speed_fast, full_duplex, tp_loopback, raw_link_ok} = 6'h00;
      {polarity_rev_pin, shared_pd_level, serial_strap} = 3'b001;
      neg_enabled = 1'b1;
      addr_strap = 5'h0A;
      neg_mode = 4'h0;
      neg_state = 4'h0;
      pd_select = 9'h000;
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge sys_clk);
      rc(5'h11, 16'hF0A0);
      chk({11'h000, phy_addr_field}, 16'h000A);
      rc(5'h12, 16'h7C00);
      rc(5'h13, 16'h0000);
      mgmt_model_inst.wr(5'h11, 16'hFFFF);
      rc(5'h11, 16'hF1F0);
      for (int i = 0; i <= 8; i++) begin
         neg_state = 4'(i);
         rc(5'h11, {12'hF1F, 4'(i)});
      end
      foreach (modes[i]) begin
         neg_done = 1'b1;
         neg_mode = modes[i];
         @(negedge sys_clk);
         neg_done = 1'b0;
         neg_mode = 4'h0;
         rc(5'h11, {modes[i], 12'h1F8});
         mgmt_model_inst.wr(5'h11, 16'h01F0);
         rc(5'h11, {modes[i], 12'h1F8});
      end
      mgmt_model_inst.wr(5'h12, 16'hFFFF);
      chk(ctl(), 16'h002F);
      polarity_rev_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      rc(5'h12, 16'h7C01);
      full_duplex = 1'b1;
      @(negedge sys_clk);
      chk(ctl(), 16'h0027);
      mgmt_model_inst.wr(5'h12, 16'h0000);
      chk(ctl(), 16'h0010);
      full_duplex = 1'b0;
      tp_loopback = 1'b1;
      @(negedge sys_clk);
      chk(ctl(), 16'h0010);
      tp_loopback = 1'b0;
      rc(5'h12, 16'h0001);
      polarity_rev_pin = 1'b0;
      full_duplex = 1'b0;
      repeat (4) @(negedge sys_clk);
      rc(5'h12, 16'h0000);
      chk(ctl(), 16'h0012);
      mgmt_model_inst.wr(5'h12, 16'hFFFF);
      speed_fast = 1'b1;
      @(negedge sys_clk);
      chk(ctl(), 16'h000C);
      raw_link_ok = 1'b1;
      @(negedge sys_clk);
      chk(ctl(), 16'h001C);
      raw_link_ok = 1'b0;
      speed_fast = 1'b0;
      mgmt_model_inst.wr(5'h13, 16'hFFFF);
      rc(5'h13, 16'h01FF);
      pd_select = 9'h0F0;
      @(negedge sys_clk);
      chk({7'h00, pd_subfunction}, 16'h010F);
      shared_pd_level = 1'b1;
      mgmt_model_inst.wr(5'h13, 16'h0000);
      chk({7'h00, pd_subfunction}, 16'h00F0);
      mgmt_model_inst.wr(5'h10, 16'hFFFF);
      rc(5'h10, 16'h0000);
      end_of_test();
   end
endmodule : tb_phy_vendor_status_config_regs
